// *** hw/nspc_pkg.sv ***
// nspc_pkg: constants and types for the burst/pseudorandom output clock controller
// How it works
// [R1] pulse width writes ignored after phase step
// [R2] divider sync re-opens pulse width control
// [R3] two function bits per divider output
// [R4] function bits pick normal, burst or random
// [R5] software never sets both function bits
// [R6] random mode: new level per divider cycle
// [R7] ten distinct 17th order random generators
// [R8] maximal 17-bit shift registers, distinct seeds
// [R9] trigger from register bit or pin
// [R10] burst settings shared across a channel
// [R11] software keeps burst divide ratio >= 8
// [R12] clock segment: six bits, divider periods
// [R13] gap segment: eight bits, divider periods
// [R14] clock zero is none, gap zero is one
// [R15] bit six picks single or periodic
// [R16] single burst: edge, pulses, gap, low
// [R17] periodic: repeat while trigger high
// [R18] trigger low: stall after current pulse
// [R19] trigger high again: resume where stalled
// [R20] primaries via modulation stage, secondaries direct
// [R21] method bit picks direct or retimed trigger
// [R22] retimed after three slowest divider edges
package nspc_pkg;
   localparam int NUM_DIV = 10;
   localparam int CH0_DIVS = 6;
   localparam int NUM_PRI = 5;
   localparam int LFSR_W = 17;
   localparam int RETIME_EDGES = 3;
   // register indices; byte address is four times the index
   localparam logic [13:0] IDX_CH0_GAP = 14'h10d2;
   localparam logic [13:0] IDX_CH0_CTL = 14'h10d3;
   localparam logic [13:0] IDX_CH0_FSEL_LO = 14'h10d4;
   localparam logic [13:0] IDX_CH0_FSEL_HI = 14'h10d5;
   localparam logic [13:0] IDX_CH0_METHOD = 14'h10d6;
   localparam logic [13:0] IDX_CH1_GAP = 14'h14d2;
   localparam logic [13:0] IDX_CH1_CTL = 14'h14d3;
   localparam logic [13:0] IDX_CH1_FSEL = 14'h14d4;
   localparam logic [13:0] IDX_CH1_METHOD = 14'h14d6;
   localparam logic [13:0] IDX_CH0_TRIG = 14'h2101;
   localparam logic [13:0] IDX_CH1_TRIG = 14'h2201;
   localparam logic [13:0] IDX_PW_SEL = 14'h2300;
   localparam logic [13:0] IDX_PW_LOCK = 14'h2301;
   localparam logic [13:0] IDX_PIN_EN = 14'h2302;
   // field positions
   localparam int CTL_PERIODIC_BIT = 6;
   localparam int METHOD_RETIME_BIT = 0;
   localparam int TRIG_BIT = 0;
   // reset values
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [16:0] LFSR_SEED_BASE = 17'h0_0001;
   localparam logic [16:0] LFSR_SEED_STEP = 17'h0_1357;
   typedef enum logic [3:0] {
      NS_IDLE = 4'b0001,
      NS_CLK = 4'b0010,
      NS_GAP = 4'b0100,
      NS_STALL = 4'b1000
   } nspc_nshot_e;
   typedef struct packed {
      logic periodic;
      logic retimed;
      logic [5:0] clkseg;
      logic [7:0] gap;
   } nspc_chcfg_s;
endpackage

// *** hw/nspc_top.sv ***
// nspc_top: per-divider output function controller with avalon register slave
//
// Decided for this implementation: the Avalon-MM register port.
`timescale 1ns/100ps
`default_nettype none
module nspc_top #(
   parameter int RETIME_EDGES = nspc_pkg::RETIME_EDGES
)(
   input wire logic mclk_i, // 40 MHz system clock
   input wire logic rstn_i, // async reset, active low
   input wire logic [15:0] avs_address_i, // byte address
   input wire logic avs_read_i, // read request
   input wire logic avs_write_i, // write request
   input wire logic [31:0] avs_writedata_i, // write data
   input wire logic [3:0] avs_byteenable_i, // byte lanes
   output logic [31:0] avs_readdata_o, // read data
   output logic avs_waitrequest_o, // stall
   input wire logic [9:0] div_i, // raw divider outputs
   input wire logic [4:0] mod_i, // modulated primary outputs
   input wire logic [4:0] mod_en_i, // modulation enabled per primary
   input wire logic status_control_pin_i, // external trigger pin
   input wire logic [2:0] ch0_slowest_i, // ch0 divider with largest phase offset
   input wire logic [1:0] ch1_slowest_i, // ch1 divider with largest phase offset
   input wire logic [9:0] phase_step_i, // subsequent phase offset executed
   input wire logic [9:0] div_sync_i, // divider synchronization
   output logic [9:0] pw_sel_o, // pulse width mode per divider
   output logic [9:0] clk_o // controller outputs
);
   localparam int N = nspc_pkg::NUM_DIV;
   localparam int NC = nspc_pkg::CH0_DIVS;

   // reset release through two flops
   logic rst_s1, rst_n;
   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         rst_s1 <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_s1 <= 1'b1;
         rst_n <= rst_s1;
      end
   end

   // [R20] primary source select
   logic [N-1:0] dv_raw;
   always_comb begin
      dv_raw = div_i;
      for (int k = 0; k < nspc_pkg::NUM_PRI; k++) begin
         if (mod_en_i[k]) begin
            dv_raw[2*k] = mod_i[k];
         end
      end
   end

   // three flop synchronisers; level moves only when stages two and three agree
   logic [N-1:0] dv_s1, dv_s2, dv_s3, dv_lvl, dv_lvl_n, dv_rise;
   logic pin_s1, pin_s2, pin_s3, pin_lvl;
   assign dv_lvl_n = (dv_s2 & dv_s3) | (dv_lvl & (dv_s2 | dv_s3));
   assign dv_rise = dv_s2 & dv_s3 & ~dv_lvl;
   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         dv_s1 <= '0;
         dv_s2 <= '0;
         dv_s3 <= '0;
         dv_lvl <= '0;
         pin_s1 <= 1'b0;
         pin_s2 <= 1'b0;
         pin_s3 <= 1'b0;
         pin_lvl <= 1'b0;
      end else begin
         dv_s1 <= dv_raw;
         dv_s2 <= dv_s1;
         dv_s3 <= dv_s2;
         dv_lvl <= dv_lvl_n;
         pin_s1 <= status_control_pin_i;
         pin_s2 <= pin_s1;
         pin_s3 <= pin_s2;
         pin_lvl <= (pin_s2 & pin_s3) | (pin_lvl & (pin_s2 | pin_s3));
      end
   end

   // bus handshake: one wait cycle, then the access completes
   logic ack_reg;
   logic req, wr_en;
   logic [13:0] widx;
   logic [7:0] wbyte;
   assign req = avs_read_i | avs_write_i;
   assign avs_waitrequest_o = req & ~ack_reg;
   assign wr_en = avs_write_i & ack_reg & avs_byteenable_i[0];
   assign widx = avs_address_i[15:2];
   assign wbyte = avs_writedata_i[7:0];
   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         ack_reg <= 1'b0;
      end else begin
         ack_reg <= req & ~ack_reg;
      end
   end

   // configuration registers
   logic [7:0] gap_reg [2];
   logic [7:0] ctl_reg [2];
   logic [7:0] trig_reg [2];
   logic [1:0] meth_reg, pin_en_reg;
   logic [7:0] fsel0lo_reg, fsel0hi_reg, fsel1_reg;
   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         gap_reg[0] <= nspc_pkg::RST_BYTE;
         gap_reg[1] <= nspc_pkg::RST_BYTE;
         ctl_reg[0] <= nspc_pkg::RST_BYTE;
         ctl_reg[1] <= nspc_pkg::RST_BYTE;
         trig_reg[0] <= nspc_pkg::RST_BYTE;
         trig_reg[1] <= nspc_pkg::RST_BYTE;
         fsel0lo_reg <= nspc_pkg::RST_BYTE;
         fsel0hi_reg <= nspc_pkg::RST_BYTE;
         fsel1_reg <= nspc_pkg::RST_BYTE;
         meth_reg <= 2'h0;
         pin_en_reg <= 2'h0;
      end else if (wr_en) begin
         case (widx)
            // [R13] gap count byte
            nspc_pkg::IDX_CH0_GAP: gap_reg[0] <= wbyte;
            nspc_pkg::IDX_CH1_GAP: gap_reg[1] <= wbyte;
            // [R12] clock count and mode
            nspc_pkg::IDX_CH0_CTL: ctl_reg[0] <= wbyte;
            nspc_pkg::IDX_CH1_CTL: ctl_reg[1] <= wbyte;
            // [R3] function bit pairs
            nspc_pkg::IDX_CH0_FSEL_LO: fsel0lo_reg <= wbyte;
            nspc_pkg::IDX_CH0_FSEL_HI: fsel0hi_reg <= wbyte;
            nspc_pkg::IDX_CH1_FSEL: fsel1_reg <= wbyte;
            nspc_pkg::IDX_CH0_TRIG: trig_reg[0] <= wbyte;
            nspc_pkg::IDX_CH1_TRIG: trig_reg[1] <= wbyte;
            nspc_pkg::IDX_CH0_METHOD: meth_reg[0] <= wbyte[nspc_pkg::METHOD_RETIME_BIT];
            nspc_pkg::IDX_CH1_METHOD: meth_reg[1] <= wbyte[nspc_pkg::METHOD_RETIME_BIT];
            nspc_pkg::IDX_PIN_EN: pin_en_reg <= wbyte[1:0];
            default: ;
         endcase
      end
   end

   // pulse width lock; a phase step in the same cycle as a sync still locks
   logic [N-1:0] lock_reg, pw_reg;
   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         lock_reg <= '0;
      end else begin
         // [R2] sync clears lock
         lock_reg <= (lock_reg & ~div_sync_i) | phase_step_i;
      end
   end

   // writes to a locked divider's bit are dropped silently
   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         pw_reg <= '0;
      end else if (wr_en && widx == nspc_pkg::IDX_PW_SEL) begin
         for (int i = 0; i < N; i++) begin
            // [R1] locked bits ignored
            if (!(lock_reg[i] | phase_step_i[i])) begin
               pw_reg[i] <= avs_writedata_i[i];
            end
         end
      end
   end
   assign pw_sel_o = pw_reg;

   // read mux, captured in the wait cycle so data stand when waitrequest drops
   logic [31:0] rd_mux, rdata_reg;
   always_comb begin
      rd_mux = 32'h0000_0000;
      case (widx)
         nspc_pkg::IDX_CH0_GAP: rd_mux[7:0] = gap_reg[0];
         nspc_pkg::IDX_CH1_GAP: rd_mux[7:0] = gap_reg[1];
         nspc_pkg::IDX_CH0_CTL: rd_mux[7:0] = ctl_reg[0];
         nspc_pkg::IDX_CH1_CTL: rd_mux[7:0] = ctl_reg[1];
         nspc_pkg::IDX_CH0_FSEL_LO: rd_mux[7:0] = fsel0lo_reg;
         nspc_pkg::IDX_CH0_FSEL_HI: rd_mux[7:0] = fsel0hi_reg;
         nspc_pkg::IDX_CH1_FSEL: rd_mux[7:0] = fsel1_reg;
         nspc_pkg::IDX_CH0_TRIG: rd_mux[7:0] = trig_reg[0];
         nspc_pkg::IDX_CH1_TRIG: rd_mux[7:0] = trig_reg[1];
         nspc_pkg::IDX_CH0_METHOD: rd_mux[0] = meth_reg[0];
         nspc_pkg::IDX_CH1_METHOD: rd_mux[0] = meth_reg[1];
         nspc_pkg::IDX_PW_SEL: rd_mux[N-1:0] = pw_reg;
         nspc_pkg::IDX_PW_LOCK: rd_mux[N-1:0] = lock_reg;
         nspc_pkg::IDX_PIN_EN: rd_mux[1:0] = pin_en_reg;
         default: rd_mux = 32'h0000_0000;
      endcase
   end
   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         rdata_reg <= 32'h0000_0000;
      end else if (avs_read_i & ~ack_reg) begin
         rdata_reg <= rd_mux;
      end
   end
   assign avs_readdata_o = rdata_reg;

   // [R10] one shared setting set per channel
   nspc_pkg::nspc_chcfg_s cfg [2];
   always_comb begin
      for (int c = 0; c < 2; c++) begin
         // [R15] mode bit
         cfg[c].periodic = ctl_reg[c][nspc_pkg::CTL_PERIODIC_BIT];
         cfg[c].retimed = meth_reg[c];
         cfg[c].clkseg = ctl_reg[c][5:0];
         cfg[c].gap = gap_reg[c];
      end
   end
   logic [19:0] fsel;
   assign fsel = {fsel1_reg, fsel0hi_reg[3:0], fsel0lo_reg};

   // [R9] register bit or pin
   logic [1:0] trig_lvl, slow_rise, eff, eff_d, evt;
   always_comb begin
      for (int c = 0; c < 2; c++) begin
         trig_lvl[c] = trig_reg[c][nspc_pkg::TRIG_BIT] | (pin_en_reg[c] & pin_lvl);
      end
      slow_rise[0] = (ch0_slowest_i > 3'd5) ? dv_rise[0] : dv_rise[ch0_slowest_i];
      slow_rise[1] = dv_rise[4'(NC) + {2'b00, ch1_slowest_i}];
   end

   // retiming: armed after the set number of slowest-divider edges
   logic [1:0] armed_reg;
   logic [1:0] rt_cnt [2];
   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         armed_reg <= 2'h0;
         rt_cnt[0] <= 2'h0;
         rt_cnt[1] <= 2'h0;
         eff_d <= 2'h0;
      end else begin
         eff_d <= eff;
         for (int c = 0; c < 2; c++) begin
            if (!trig_lvl[c]) begin
               armed_reg[c] <= 1'b0;
               rt_cnt[c] <= 2'h0;
            end else if (!armed_reg[c] && slow_rise[c]) begin
               // [R22] third slowest edge
               if (rt_cnt[c] == 2'(RETIME_EDGES - 1)) begin
                  armed_reg[c] <= 1'b1;
               end else begin
                  rt_cnt[c] <= rt_cnt[c] + 2'd1;
               end
            end
         end
      end
   end
   // [R21] direct or retimed
   assign eff = ({meth_reg[1], meth_reg[0]} & armed_reg & trig_lvl) | (~meth_reg & trig_lvl);
   assign evt = eff & ~eff_d;

   // per-divider state
   nspc_pkg::nspc_nshot_e st_reg [N];
   nspc_pkg::nspc_nshot_e st_next [N];
   logic [7:0] cnt_reg [N];
   logic [7:0] cnt_next [N];
   logic [16:0] lfsr_reg [N];
   logic [16:0] lfsr_next [N];
   logic [N-1:0] pend_reg, pend_next, out_next, clk_reg;

   // burst sequencer, random generators and output select
   always_comb begin
      int c;
      logic ns_en, pr_en, per, trig, start;
      logic [8:0] nseg, gseg, cnt1;
      c = 0;
      ns_en = 1'b0;
      pr_en = 1'b0;
      per = 1'b0;
      trig = 1'b0;
      start = 1'b0;
      nseg = 9'h000;
      gseg = 9'h000;
      cnt1 = 9'h000;
      for (int i = 0; i < N; i++) begin
         c = (i >= NC) ? 1 : 0;
         ns_en = fsel[2*i] & ~fsel[2*i+1];
         pr_en = fsel[2*i+1] & ~fsel[2*i];
         per = cfg[c].periodic;
         trig = eff[c];
         start = per ? trig : pend_reg[i];
         nseg = {3'b000, cfg[c].clkseg};
         // [R14] gap zero gives one
         gseg = (cfg[c].gap == 8'h00) ? 9'h001 : {1'b0, cfg[c].gap};
         cnt1 = {1'b0, cnt_reg[i]} + 9'h001;
         st_next[i] = st_reg[i];
         cnt_next[i] = cnt_reg[i];
         // a trigger edge is held until a divider rising edge in NS_IDLE takes it
         pend_next[i] = ns_en & ~per & (evt[c] | (pend_reg[i] & ~(dv_rise[i] & st_reg[i] == nspc_pkg::NS_IDLE)));
         if (!ns_en) begin
            st_next[i] = nspc_pkg::NS_IDLE;
            cnt_next[i] = 8'h00;
         end else if (dv_rise[i]) begin
            case (st_reg[i])
               // [R16] start on trigger
               nspc_pkg::NS_IDLE: begin
                  if (start) begin
                     cnt_next[i] = 8'h00;
                     st_next[i] = (nseg == 9'h000) ? nspc_pkg::NS_GAP : nspc_pkg::NS_CLK;
                  end
               end
               // [R19] resume stalled pattern
               nspc_pkg::NS_STALL: begin
                  if (!per) begin
                     st_next[i] = nspc_pkg::NS_IDLE;
                  end else if (trig) begin
                     st_next[i] = (nseg == 9'h000) ? nspc_pkg::NS_GAP : nspc_pkg::NS_CLK;
                  end
               end
               // [R12] count clock pulses
               nspc_pkg::NS_CLK: begin
                  if (cnt1 >= nseg) begin
                     st_next[i] = nspc_pkg::NS_GAP;
                     cnt_next[i] = 8'h00;
                  end else begin
                     cnt_next[i] = cnt1[7:0];
                     // [R18] stall after pulse
                     if (per & ~trig) begin
                        st_next[i] = nspc_pkg::NS_STALL;
                     end
                  end
               end
               // [R13] count gap periods
               nspc_pkg::NS_GAP: begin
                  if (cnt1 >= gseg) begin
                     cnt_next[i] = 8'h00;
                     // [R17] repeat while high
                     if (per & trig) begin
                        st_next[i] = (nseg == 9'h000) ? nspc_pkg::NS_GAP : nspc_pkg::NS_CLK;
                     end else begin
                        st_next[i] = per ? nspc_pkg::NS_STALL : nspc_pkg::NS_IDLE;
                     end
                  end else begin
                     cnt_next[i] = cnt1[7:0];
                  end
               end
               default: st_next[i] = nspc_pkg::NS_IDLE;
            endcase
         end
         // [R6] shift once per divider cycle
         lfsr_next[i] = lfsr_reg[i];
         if (dv_rise[i]) begin
            // [R8] x^17 + x^14 + 1
            lfsr_next[i] = {lfsr_reg[i][15:0], lfsr_reg[i][16] ^ lfsr_reg[i][13]};
         end
         // [R4] output function select; both bits set gives a quiet low output
         if (ns_en) begin
            out_next[i] = (st_next[i] == nspc_pkg::NS_CLK) & dv_lvl_n[i];
         end else if (pr_en) begin
            out_next[i] = lfsr_next[i][0];
         end else begin
            out_next[i] = ~fsel[2*i] & dv_lvl_n[i];
         end
      end
   end

   // [R7] ten generators, distinct seeds
   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < N; i++) begin
            st_reg[i] <= nspc_pkg::NS_IDLE;
            cnt_reg[i] <= 8'h00;
            lfsr_reg[i] <= nspc_pkg::LFSR_SEED_BASE + 17'(i) * nspc_pkg::LFSR_SEED_STEP;
         end
         pend_reg <= '0;
         clk_reg <= '0;
      end else begin
         for (int i = 0; i < N; i++) begin
            st_reg[i] <= st_next[i];
            cnt_reg[i] <= cnt_next[i];
            lfsr_reg[i] <= lfsr_next[i];
         end
         pend_reg <= pend_next;
         clk_reg <= out_next;
      end
   end
   assign clk_o = clk_reg;

endmodule // nspc_top
`default_nettype wire

// *** verif/nspc_div_model.sv ***
// divider bank model driving the controller
`timescale 1ns/100ps
`default_nettype none
module nspc_div_model #(
   parameter int HALF = 6, // divider half period in mclk
   parameter int MHALF = 9 // modulated clock half period in mclk
)(
   input wire logic mclk_i, // system clock
   input wire logic rstn_i, // reset, active low
   output logic [9:0] div_o, // divider outputs
   output logic [4:0] mod_o // modulated primaries
);
   int dcnt, mcnt;
   // ratio of twelve
   // half period above sync depth: no edge lost
   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         dcnt <= 0;
         mcnt <= 0;
         div_o <= '0;
         mod_o <= '0;
      end else begin
         dcnt <= (dcnt == HALF - 1) ? 0 : dcnt + 1;
         mcnt <= (mcnt == MHALF - 1) ? 0 : mcnt + 1;
         if (dcnt == HALF - 1) div_o <= ~div_o;
         if (mcnt == MHALF - 1) mod_o <= ~mod_o;
      end
   end
endmodule // nspc_div_model
`default_nettype wire

// *** verif/nspc_props.sv ***
// assertions on the controller's ports
`timescale 1ns/100ps
`default_nettype none
module nspc_props (
   input wire logic mclk_i, // clock
   input wire logic rstn_i, // reset, active low
   input wire logic [15:0] avs_address_i, // byte address
   input wire logic avs_read_i, // read
   input wire logic avs_write_i, // write
   input wire logic [31:0] avs_writedata_i, // write data
   input wire logic [3:0] avs_byteenable_i, // lanes
   input wire logic [31:0] avs_readdata_o, // read data
   input wire logic avs_waitrequest_o, // stall
   input wire logic [9:0] div_i, // dividers
   input wire logic [9:0] phase_step_i, // phase step
   input wire logic [9:0] div_sync_i, // divider sync
   input wire logic [9:0] pw_sel_o, // pulse width mode
   input wire logic [9:0] clk_o // outputs
);
   logic req;
   logic [9:0] lock_q;
   assign req = avs_read_i | avs_write_i;
   // lock shadow; set wins over sync
   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) lock_q <= '0;
      else lock_q <= (lock_q & ~div_sync_i) | phase_step_i;
   end
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!rstn_i);
   sequence s_one_wait;
      avs_waitrequest_o ##1 !avs_waitrequest_o;
   endsequence
   sequence s_pw_write;
      avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0] && avs_address_i[15:2] == nspc_pkg::IDX_PW_SEL;
   endsequence
   wait_one_cycle_a: assert property ($rose(req) |-> s_one_wait)
      else $error("not one wait cycle");
   idle_no_wait_a: assert property (!req |-> !avs_waitrequest_o)
      else $error("wait while idle");
   rd_upper_zero_a: assert property (avs_read_i && !avs_waitrequest_o |-> avs_readdata_o[31:10] == '0)
      else $error("upper read bits set");
   rd_hold_a: assert property (!avs_read_i |=> $stable(avs_readdata_o))
      else $error("read data moved");
   pw_write_only_a: assert property ($changed(pw_sel_o) |-> $past(avs_write_i && !avs_waitrequest_o))
      else $error("pw moved unwritten");
   pw_write_open_a: assert property (s_pw_write ##0 (lock_q | phase_step_i) == '0
      |=> pw_sel_o == $past(avs_writedata_i[9:0])) else $error("open pw write lost");
   pw_lock_hold_a: assert property (|lock_q |=> ((pw_sel_o ^ $past(pw_sel_o)) & $past(lock_q)) == '0)
      else $error("locked pw changed");
   sec_out_follow_a: assert property ((clk_o & ~$past(clk_o) & 10'h2aa
      & ~($past(div_i, 3) | $past(div_i, 4) | $past(div_i, 5) | $past(div_i, 6))) == '0)
      else $error("rise without divider");
endmodule // nspc_props
bind nspc_top nspc_props i_nspc_props (.mclk_i, .rstn_i, .avs_address_i, .avs_read_i, .avs_write_i,
   .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o, .div_i, .phase_step_i,
   .div_sync_i, .pw_sel_o, .clk_o);
`default_nettype wire

// *** verif/tb_top.sv ***
// self-checking bench for the controller
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin fails++; $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (b)); end end
module tb_top;
   localparam int P = 12; // divider period in mclk
   logic mclk_i = 1'b0;
   logic rstn_i = 1'b0;
   logic [15:0] adr = '0;
   logic rd = 1'b0, wr = 1'b0, pin = 1'b0;
   logic [31:0] wd = '0, rdata, q;
   logic [3:0] be = 4'h1;
   logic wait_o;
   logic [9:0] div, pw_sel, clk;
   logic [9:0] clk_q = '0, pstep = '0, dsync = '0;
   logic [4:0] mod;
   logic [4:0] mod_en = '0;
   int fails = 0, n_tests = 0;
   int cnt [10];
   logic [13:0] rw [9] = '{nspc_pkg::IDX_CH0_GAP, nspc_pkg::IDX_CH0_CTL, nspc_pkg::IDX_CH0_FSEL_LO,
      nspc_pkg::IDX_CH0_FSEL_HI, nspc_pkg::IDX_CH1_GAP, nspc_pkg::IDX_CH1_CTL, nspc_pkg::IDX_CH1_FSEL,
      nspc_pkg::IDX_CH0_TRIG, nspc_pkg::IDX_CH1_TRIG};
   nspc_top i_nspc_top (.mclk_i(mclk_i), .rstn_i(rstn_i), .avs_address_i(adr), .avs_read_i(rd),
      .avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(be), .avs_readdata_o(rdata),
      .avs_waitrequest_o(wait_o), .div_i(div), .mod_i(mod), .mod_en_i(mod_en), .status_control_pin_i(pin),
      .ch0_slowest_i(3'h3), .ch1_slowest_i(2'h0), .phase_step_i(pstep), .div_sync_i(dsync),
      .pw_sel_o(pw_sel), .clk_o(clk));
   nspc_div_model i_nspc_div_model (.mclk_i(mclk_i), .rstn_i(rstn_i), .div_o(div), .mod_o(mod));
   // system clock
   always #12.5 mclk_i = ~mclk_i;
   // count output rises
   always @(posedge mclk_i) begin
      clk_q <= clk;
      for (int i = 0; i < 10; i++) if (clk[i] && !clk_q[i]) cnt[i]++;
   end
   // cleared off the edge to avoid a race
   task automatic clr;
      @(negedge mclk_i);
      cnt = '{default: 0};
   endtask
   // one access, held until waitrequest sampled low at a rising edge
   task automatic bus(input logic w, input logic [13:0] idx, input logic [31:0] d);
      int t = 0;
      @(posedge mclk_i);
      adr <= {idx, 2'b00};
      wd <= d;
      wr <= w;
      rd <= !w;
      do begin
         @(posedge mclk_i);
         t++;
      end while (wait_o !== 1'b0 && t < 50);
      q = rdata;
      wr <= 1'b0;
      rd <= 1'b0;
      if (t >= 50) fails++;
   endtask
   function automatic logic [7:0] pk(input logic [3:0] n, input logic [3:0] p);
      return {p[3], n[3], p[2], n[2], p[1], n[1], p[0], n[0]};
   endfunction
   task automatic funcs(input logic [9:0] n, input logic [9:0] p);
      bus(1, nspc_pkg::IDX_CH0_FSEL_LO, 32'(pk(n[3:0], p[3:0])));
      bus(1, nspc_pkg::IDX_CH0_FSEL_HI, 32'(pk({2'b00, n[5:4]}, {2'b00, p[5:4]})));
      bus(1, nspc_pkg::IDX_CH1_FSEL, 32'(pk(n[9:6], p[9:6])));
   endtask
   task automatic shot(input int ch, input logic per, input int c, input int g);
      bus(1, ch ? nspc_pkg::IDX_CH1_GAP : nspc_pkg::IDX_CH0_GAP, 32'(g));
      bus(1, ch ? nspc_pkg::IDX_CH1_CTL : nspc_pkg::IDX_CH0_CTL, 32'({per, 6'(c)}));
   endtask
   task automatic trig(input int ch, input logic v);
      bus(1, ch ? nspc_pkg::IDX_CH1_TRIG : nspc_pkg::IDX_CH0_TRIG, 32'(v));
   endtask
   task automatic end_sim;
      $display("comparisons %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   // watchdog above the run length
   initial begin
      repeat (60000) @(posedge mclk_i);
      fails++;
      end_sim;
   end
   initial begin
      logic [7:0] d;
      int c, g, t0, lat;
      void'($urandom(32'he262_7bd0));
      repeat (12) @(posedge mclk_i);
      rstn_i <= 1'b1;
      repeat (4) @(posedge mclk_i);
      // reset values, read back; no pair both set
      foreach (rw[i]) begin
         bus(0, rw[i], 0);
         `CHK(q, 32'h0)
         d = $urandom;
         d = d & ~((d & 8'h55) << 1);
         bus(1, rw[i], 32'(d));
         bus(0, rw[i], 0);
         `CHK(q, 32'(d))
         bus(1, rw[i], 0);
      end
      bus(1, 14'h0005, 32'h0000_00ff);
      bus(0, 14'h0005, 0);
      `CHK(q, 32'h0)
      be <= 4'h0;
      bus(1, nspc_pkg::IDX_CH0_GAP, 32'h0000_00ff);
      be <= 4'h1;
      bus(0, nspc_pkg::IDX_CH0_GAP, 0);
      `CHK(q, 32'h0)
      bus(1, nspc_pkg::IDX_CH0_METHOD, 32'h0000_00ff);
      bus(0, nspc_pkg::IDX_CH0_METHOD, 0);
      `CHK(q, 32'h1)
      bus(1, nspc_pkg::IDX_CH0_METHOD, 0);
      $display("test registers done");
      // plain clock; primary from modulation stage
      mod_en <= 5'h01;
      clr;
      repeat (60 * P) @(posedge mclk_i);
      `CHK(cnt[1] inside {[59:61]}, 1'b1)
      `CHK(cnt[0] inside {[39:41]}, 1'b1)
      mod_en <= 5'h00;
      $display("test normal done");
      // single bursts, one per trigger edge
      funcs(10'h00a, 10'h000);
      for (int k = 0; k < 4; k++) begin
         c = (k == 0) ? 0 : (k == 3) ? 63 : $urandom_range(20, 1);
         g = (k == 0) ? 0 : $urandom_range(255, 0);
         shot(0, 1'b0, c, g);
         clr;
         trig(0, 1'b1);
         repeat ((c + g + 4) * P) @(posedge mclk_i);
         `CHK(cnt[1], c)
         `CHK(cnt[3], cnt[1])
         trig(0, 1'b0);
      end
      $display("test burst done");
      // periodic clock, stopped by trigger low
      for (int k = 0; k < 2; k++) begin
         c = k ? 3 : 2;
         g = k ? $urandom_range(9, 1) : 0;
         shot(0, 1'b1, c, g);
         clr;
         trig(0, 1'b1);
         repeat (60 * P) @(posedge mclk_i);
         trig(0, 1'b0);
         repeat (3 * P) @(posedge mclk_i);
         t0 = cnt[1];
         `CHK((t0 - 60 * c / (c + (g ? g : 1))) inside {[-c - 1:c + 1]}, 1'b1)
         repeat (20 * P) @(posedge mclk_i);
         `CHK(cnt[1], t0)
      end
      // stall mid clock segment, then resume; burst bits cycled to drop a stale stall
      funcs(0, 0);
      funcs(10'h00a, 0);
      shot(0, 1'b1, 4, 250);
      clr;
      trig(0, 1'b1);
      repeat (P) @(posedge mclk_i);
      trig(0, 1'b0);
      repeat (5 * P) @(posedge mclk_i);
      `CHK(cnt[1] inside {[1:3]}, 1'b1)
      trig(0, 1'b1);
      repeat (10 * P) @(posedge mclk_i);
      trig(0, 1'b0);
      `CHK(cnt[1], 4)
      $display("test periodic done");
      // random clocks on three outputs
      funcs(10'h000, 10'h02a);
      repeat (4 * P) @(posedge mclk_i);
      t0 = 0;
      c = 0;
      g = 0;
      for (int k = 0; k < 64; k++) begin
         @(posedge div[1]);
         repeat (P / 2) @(posedge mclk_i);
         t0 += int'(clk[1]);
         c += int'(clk[1] != clk[3]);
         g += int'(clk[3] != clk[5]);
      end
      `CHK(t0 inside {[8:56]}, 1'b1)
      `CHK(c > 0 && g > 0, 1'b1)
      $display("test random done");
      // pin trigger ch0, register trigger ch1
      funcs(10'h082, 10'h000);
      shot(0, 1'b0, 3, 2);
      shot(1, 1'b0, 2, 2);
      bus(1, nspc_pkg::IDX_PIN_EN, 32'h1);
      clr;
      pin <= 1'b1;
      repeat (P) @(posedge mclk_i);
      pin <= 1'b0;
      trig(1, 1'b1);
      repeat (20 * P) @(posedge mclk_i);
      trig(1, 1'b0);
      `CHK(cnt[1], 3)
      `CHK(cnt[7], 2)
      bus(1, nspc_pkg::IDX_PIN_EN, 0);
      // direct against retimed trigger latency
      funcs(10'h00a, 10'h000);
      shot(0, 1'b0, 1, 0);
      for (int k = 0; k < 2; k++) begin
         bus(1, nspc_pkg::IDX_CH0_METHOD, 32'(k));
         clr;
         trig(0, 1'b1);
         lat = 0;
         while (cnt[1] == 0 && lat < 100) begin
            @(posedge mclk_i);
            lat++;
         end
         trig(0, 1'b0);
         if (k == 0) c = lat;
      end
      `CHK(lat - c > P && lat < 100, 1'b1)
      $display("test trigger done");
      // pw lock by phase step, reopened by sync
      bus(1, nspc_pkg::IDX_PW_SEL, 32'h0000_03ff);
      pstep <= 10'h001;
      @(posedge mclk_i);
      pstep <= '0;
      bus(1, nspc_pkg::IDX_PW_SEL, 0);
      bus(0, nspc_pkg::IDX_PW_SEL, 0);
      `CHK(q, 32'h1)
      bus(0, nspc_pkg::IDX_PW_LOCK, 0);
      `CHK(q, 32'h1)
      dsync <= 10'h001;
      @(posedge mclk_i);
      dsync <= '0;
      bus(1, nspc_pkg::IDX_PW_SEL, 0);
      bus(0, nspc_pkg::IDX_PW_SEL, 0);
      `CHK(q, 32'h0)
      $display("test pulse width done");
      end_sim;
   end
endmodule // tb_top
`default_nettype wire
